// file: design/qsp_consts.svh
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH

// ----------------------------------------
// Sizes and rates
// ----------------------------------------
`define QSP_FIFO_DEPTH 16
`define QSP_CLK_HZ     200000000
`define QSP_MAX_BAUD   921600
`define QSP_SLOW_BPS   250000

// ----------------------------------------
// Channel register offsets
// ----------------------------------------
`define QSP_A_DATA 3'h0
`define QSP_A_IER  3'h1
`define QSP_A_IIR  3'h2
`define QSP_A_LCR  3'h3
`define QSP_A_MCR  3'h4
`define QSP_A_LSR  3'h5
`define QSP_A_MSR  3'h6
`define QSP_A_SCR  3'h7

// ----------------------------------------
// Interrupt identity codes
// ----------------------------------------
`define QSP_IID_NONE 4'h1
`define QSP_IID_LSE  4'h6
`define QSP_IID_RXD  4'h4
`define QSP_IID_THRE 4'h2
`define QSP_IID_MDM  4'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QSP_CFG_RST 7'h7F
`define QSP_LCR_RST 8'h00
`define QSP_DIV_RST 16'h0001

`endif

// file: design/qsp_pkg.sv
`include "qsp_consts.svh"

package qsp_pkg;

	typedef enum logic [1:0] {
		QSP_RS232 = 2'b00,
		QSP_RS485 = 2'b01,
		QSP_RS422 = 2'b10
	} qsp_mode_t;

	typedef enum logic [1:0] {
		QSP_IDLE  = 2'b00,
		QSP_START = 2'b01,
		QSP_DATA  = 2'b10,
		QSP_STOP  = 2'b11
	} qsp_ser_t;

	typedef struct packed {
		logic       we;
		logic       re;
		logic [1:0] ch;
		logic [2:0] addr;
		logic [7:0] wdata;
	} qsp_req_t;

	typedef struct packed {
		logic ch3_rs232_select;
		logic ch3_rs422_select;
		logic ch3_termination_n;
		logic ch3_slew_limit_n;
		logic ch4_rs485_select;
		logic ch4_termination_n;
		logic ch4_slew_limit_n;
	} qsp_cfg_t;

	function automatic qsp_mode_t qsp_ch3_mode(input qsp_cfg_t c);
		if (c.ch3_rs232_select) begin
			return QSP_RS232;
		end
		return c.ch3_rs422_select ? QSP_RS422 : QSP_RS485;
	endfunction

	function automatic logic [3:0] qsp_iid(input logic [3:0] ier, input logic lse,
		input logic rxe, input logic thre, input logic mdm);
		if (ier[2] && lse) begin
			return `QSP_IID_LSE;
		end
		if (ier[0] && rxe) begin
			return `QSP_IID_RXD;
		end
		if (ier[1] && thre) begin
			return `QSP_IID_THRE;
		end
		if (ier[3] && mdm) begin
			return `QSP_IID_MDM;
		end
		return `QSP_IID_NONE;
	endfunction

endpackage

// file: design/qsp_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_chan
	import qsp_pkg::*;
#(
	parameter int DEPTH = `QSP_FIFO_DEPTH
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire qsp_req_t   req,
	input  wire logic       sel,
	output logic [7:0]      rd_val,
	input  wire logic       rxd,
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       dcd_n,
	input  wire logic       ri_n,
	output logic            txd,
	output logic            rts_n,
	output logic            dtr_n,
	output logic            irq
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("DEPTH must be a power of two, at least 16");
	end

	logic [7:0]    rxm [DEPTH];
	logic [7:0]    txm [DEPTH];
	logic [3:0]    ier_reg, ier_next, mdm_d_reg, mdm_d_next, mdm_p_reg, mdm_p_next;
	logic [7:0]    lcr_reg, lcr_next, scr_reg, scr_next, rx_sh_reg, rx_sh_next;
	logic [7:0]    tx_sh_reg, tx_sh_next;
	logic [4:0]    mcr_reg, mcr_next;
	logic [15:0]   div_reg, div_next, bd_reg, bd_next;
	logic [1:0]    trig_reg, trig_next;
	logic [AW:0]   rwp_reg, rwp_next, rrp_reg, rrp_next, twp_reg, twp_next, trp_reg, trp_next;
	qsp_ser_t      rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;
	logic [3:0]    rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
	logic [2:0]    rx_bit_reg, rx_bit_next, tx_bit_reg, tx_bit_next;
	logic          txd_reg, txd_next, oe_reg, oe_next, fe_reg, fe_next, thre_reg, thre_next;
	logic          tick, wr, rd, rx_push, rx_pop, tx_push, tx_pop, dlab, loop, rx_in, rx_hit;
	logic [AW:0]   rx_lvl, tx_lvl, trig_lvl;
	logic [3:0]    mdm_now, iid;
	logic [7:0]    lsr, rx_word;
	logic [2:0]    wl_m1;

	assign rx_lvl   = rwp_reg - rrp_reg;
	assign tx_lvl   = twp_reg - trp_reg;
	assign trig_lvl = (AW + 1)'(trig_reg == 2'h0 ? 1 : trig_reg == 2'h1 ? 4 :
		trig_reg == 2'h2 ? 8 : 14);
	assign rx_hit   = rx_lvl >= trig_lvl;
	assign dlab     = lcr_reg[7];
	assign loop     = mcr_reg[4];
	assign wl_m1    = {1'b1, lcr_reg[1:0]};
	assign rx_in    = loop ? txd_reg : rxd;
	assign mdm_now  = loop ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]} :
		{~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
	assign lsr      = {oe_reg | fe_reg, tx_lvl == '0 && tx_st_reg == QSP_IDLE,
		tx_lvl == '0, 1'b0, fe_reg, 1'b0, oe_reg, rx_lvl != '0};
	assign rx_word  = rx_sh_reg >> (3'h7 - wl_m1);
	assign iid      = qsp_iid(ier_reg, oe_reg | fe_reg, rx_hit, thre_reg, |mdm_d_reg);
	// Interrupt line per channel
	assign irq      = ~iid[0];
	assign txd      = loop | txd_reg;
	assign rts_n    = loop | ~mcr_reg[1];
	assign dtr_n    = loop | ~mcr_reg[0];

	// ----------------------------------------
	// Register model, baud, receive, transmit
	// ----------------------------------------
	always_comb begin
		ier_next = ier_reg;
		lcr_next = lcr_reg;
		mcr_next = mcr_reg;
		scr_next = scr_reg;
		div_next = div_reg;
		trig_next = trig_reg;
		rx_st_next = rx_st_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next = rx_sh_reg;
		tx_st_next = tx_st_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_bit_next = tx_bit_reg;
		tx_sh_next = tx_sh_reg;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		oe_next = oe_reg;
		fe_next = fe_reg;
		thre_next = thre_reg;
		mdm_d_next = mdm_d_reg;
		mdm_p_next = mdm_now;
		rd_val = 8'h00;
		wr = sel & req.we;
		rd = sel & req.re;
		// 16x sample tick from divisor
		tick = bd_reg == 16'h0000;
		bd_next = tick ? ((div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001) :
			bd_reg - 16'h0001;
		// Host side of the 16550 register model
		if (rd) begin
			unique case (req.addr)
				`QSP_A_DATA: begin
					rd_val = dlab ? div_reg[7:0] : rxm[rrp_reg[AW-1:0]];
					rx_pop = !dlab && rx_lvl != '0;
				end
				`QSP_A_IER: rd_val = dlab ? div_reg[15:8] : {4'h0, ier_reg};
				`QSP_A_IIR: begin
					rd_val = {4'hC, iid};
					if (iid == `QSP_IID_THRE) begin
						thre_next = 1'b0;
					end
				end
				`QSP_A_LCR: rd_val = lcr_reg;
				`QSP_A_MCR: rd_val = {3'h0, mcr_reg};
				`QSP_A_LSR: begin
					rd_val = lsr;
					oe_next = 1'b0;
					fe_next = 1'b0;
				end
				`QSP_A_MSR: begin
					rd_val = {mdm_now, mdm_d_reg};
					mdm_d_next = 4'h0;
				end
				`QSP_A_SCR: rd_val = scr_reg;
			endcase
		end
		if (wr) begin
			unique case (req.addr)
				`QSP_A_DATA: begin
					if (dlab) begin
						div_next[7:0] = req.wdata;
					end else begin
						tx_push = tx_lvl != (AW + 1)'(DEPTH);
						thre_next = 1'b0;
					end
				end
				`QSP_A_IER: begin
					if (dlab) begin
						div_next[15:8] = req.wdata;
					end else begin
						ier_next = req.wdata[3:0];
						if (req.wdata[1] && !ier_reg[1] && tx_lvl == '0) begin
							thre_next = 1'b1;
						end
					end
				end
				`QSP_A_IIR: trig_next = req.wdata[7:6];
				`QSP_A_LCR: lcr_next = req.wdata;
				`QSP_A_MCR: mcr_next = req.wdata[4:0];
				`QSP_A_SCR: scr_next = req.wdata;
				default: ;
			endcase
		end
		// Receiver, mid-bit sampling
		unique case (rx_st_reg)
			QSP_IDLE: begin
				if (!rx_in) begin
					rx_st_next = QSP_START;
					rx_cnt_next = 4'h0;
				end
			end
			QSP_START: begin
				if (tick) begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == 4'h7) begin
						rx_cnt_next = 4'h0;
						rx_bit_next = 3'h0;
						rx_st_next = rx_in ? QSP_IDLE : QSP_DATA;
					end
				end
			end
			QSP_DATA: begin
				if (tick) begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == 4'hF) begin
						rx_sh_next = {rx_in, rx_sh_reg[7:1]};
						rx_bit_next = rx_bit_reg + 3'h1;
						if (rx_bit_reg == wl_m1) begin
							rx_st_next = QSP_STOP;
						end
					end
				end
			end
			QSP_STOP: begin
				if (tick) begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == 4'hF) begin
						rx_st_next = QSP_IDLE;
						// Error flags: set wins over read clear
						if (rx_lvl == (AW + 1)'(DEPTH)) begin
							oe_next = 1'b1;
						end else begin
							rx_push = 1'b1;
						end
						if (!rx_in) begin
							fe_next = 1'b1;
						end
					end
				end
			end
		endcase
		// Transmitter
		unique case (tx_st_reg)
			QSP_IDLE: begin
				if (tick && tx_lvl != '0) begin
					tx_pop = 1'b1;
					tx_sh_next = txm[trp_reg[AW-1:0]];
					tx_st_next = QSP_START;
					tx_cnt_next = 4'h0;
					if (tx_lvl == (AW + 1)'(1)) begin
						thre_next = 1'b1;
					end
				end
			end
			QSP_START: begin
				if (tick) begin
					tx_cnt_next = tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == 4'hF) begin
						tx_st_next = QSP_DATA;
						tx_bit_next = 3'h0;
					end
				end
			end
			QSP_DATA: begin
				if (tick) begin
					tx_cnt_next = tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == 4'hF) begin
						tx_sh_next = {1'b1, tx_sh_reg[7:1]};
						tx_bit_next = tx_bit_reg + 3'h1;
						if (tx_bit_reg == wl_m1) begin
							tx_st_next = QSP_STOP;
							tx_bit_next = 3'h0;
						end
					end
				end
			end
			QSP_STOP: begin
				if (tick) begin
					tx_cnt_next = tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == 4'hF) begin
						tx_bit_next = tx_bit_reg + 3'h1;
						if (tx_bit_reg == {2'b00, lcr_reg[2]}) begin
							tx_st_next = QSP_IDLE;
						end
					end
				end
			end
		endcase
		unique case (tx_st_next)
			QSP_START: txd_next = 1'b0;
			QSP_DATA:  txd_next = tx_sh_next[0];
			QSP_IDLE,
			QSP_STOP:  txd_next = 1'b1;
		endcase
		if (lcr_reg[6]) begin
			txd_next = 1'b0;
		end
		mdm_d_next = mdm_d_next | {mdm_now[3] ^ mdm_p_reg[3], mdm_p_reg[2] & ~mdm_now[2],
			mdm_now[1:0] ^ mdm_p_reg[1:0]};
		// DEPTH-entry FIFOs, 16 entries by default
		rwp_next = rx_push ? rwp_reg + (AW + 1)'(1) : rwp_reg;
		rrp_next = rx_pop ? rrp_reg + (AW + 1)'(1) : rrp_reg;
		twp_next = tx_push ? twp_reg + (AW + 1)'(1) : twp_reg;
		trp_next = tx_pop ? trp_reg + (AW + 1)'(1) : trp_reg;
		if (wr && !dlab && req.addr == `QSP_A_IIR) begin
			if (req.wdata[1]) begin
				rrp_next = rwp_next;
			end
			if (req.wdata[2]) begin
				trp_next = twp_next;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rx_push) begin
			rxm[rwp_reg[AW-1:0]] <= rx_word;
		end
		if (tx_push) begin
			txm[twp_reg[AW-1:0]] <= req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ier_reg <= 4'h0;
			lcr_reg <= `QSP_LCR_RST;
			mcr_reg <= 5'h00;
			scr_reg <= 8'h00;
			div_reg <= `QSP_DIV_RST;
			bd_reg <= 16'h0000;
			trig_reg <= 2'h0;
			{rwp_reg, rrp_reg, twp_reg, trp_reg} <= '0;
			rx_st_reg <= QSP_IDLE;
			tx_st_reg <= QSP_IDLE;
			{rx_cnt_reg, tx_cnt_reg, rx_bit_reg, tx_bit_reg} <= '0;
			{rx_sh_reg, tx_sh_reg} <= 16'h0000;
			txd_reg <= 1'b1;
			{oe_reg, fe_reg, thre_reg} <= 3'h0;
			{mdm_d_reg, mdm_p_reg} <= 8'h00;
		end else begin
			ier_reg <= ier_next;
			lcr_reg <= lcr_next;
			mcr_reg <= mcr_next;
			scr_reg <= scr_next;
			div_reg <= div_next;
			bd_reg <= bd_next;
			trig_reg <= trig_next;
			{rwp_reg, rrp_reg, twp_reg, trp_reg} <= {rwp_next, rrp_next, twp_next, trp_next};
			rx_st_reg <= rx_st_next;
			tx_st_reg <= tx_st_next;
			{rx_cnt_reg, tx_cnt_reg} <= {rx_cnt_next, tx_cnt_next};
			{rx_bit_reg, tx_bit_reg} <= {rx_bit_next, tx_bit_next};
			{rx_sh_reg, tx_sh_reg} <= {rx_sh_next, tx_sh_next};
			txd_reg <= txd_next;
			{oe_reg, fe_reg, thre_reg} <= {oe_next, fe_next, thre_next};
			{mdm_d_reg, mdm_p_reg} <= {mdm_d_next, mdm_p_next};
		end
	end

	fifo_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_lvl <= (AW + 1)'(DEPTH) && tx_lvl <= (AW + 1)'(DEPTH))
		else $error("fifo level beyond depth");
	tx_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_st_reg == QSP_IDLE && tick && tx_lvl != '0 && !lcr_reg[6]
		|=> tx_st_reg == QSP_START && !txd_reg ##1 (tx_lvl == $past(tx_lvl, 2) - 1'b1
			|| $past(wr) || $past(wr, 2)))
		else $error("transmit start bit not sent");
	irq_thre_a: assert property (@(posedge mclk) disable iff (!rst_n)
		thre_reg && ier_reg[1] && !oe_reg && !fe_reg |-> irq)
		else $error("pending transmit interrupt not signalled");

endmodule
`default_nettype wire

// file: design/qsp_top.sv
// Operation
// - Four independent channels, each behaving like a 16550 serial port.
// - Channels one and two are RS232 with modem lines, up to 921.6 Kbaud.
// - Third channel switches by software between RS232 and RS485/RS422.
// - RS232 select high gives RS232; both low RS485; else RS422.
// - Both third-channel select lines reset to one, starting in RS232.
// - Termination control low connects 120 ohm termination; resets high.
// - Slew control low selects reduced slew, limiting rate near 250 kbps.
// - Fourth channel offers only RS422 or RS485, never RS232.
// - In RS485 request-to-send low drives the line; transmit echoes back.
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module qsp_top
	import qsp_pkg::*;
#(
	parameter int DEPTH = `QSP_FIFO_DEPTH
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire qsp_req_t   host_req,
	output logic [7:0]      host_rdata,
	output logic [3:0]      chan_irq,
	input  wire logic       cfg_we,
	input  wire qsp_cfg_t   cfg_wdata,
	output qsp_cfg_t        cfg,
	input  wire logic [2:0] rs232_rxd,
	output logic [2:0]      rs232_txd,
	input  wire logic [2:0] rs232_cts_n,
	input  wire logic [2:0] rs232_dsr_n,
	input  wire logic [2:0] rs232_dcd_n,
	input  wire logic [2:0] rs232_ri_n,
	output logic [2:0]      rs232_rts_n,
	output logic [2:0]      rs232_dtr_n,
	input  wire logic [1:0] diff_rxd,
	output logic [1:0]      diff_txd,
	output logic [1:0]      diff_drv_en
);
	if (`QSP_CLK_HZ / 16 < `QSP_MAX_BAUD) begin : g_chk
		$error("clock too slow for the top baud rate");
	end

	qsp_cfg_t   cfg_reg, cfg_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] c_rd [4];
	logic [3:0] c_rxd, c_txd, c_rts_n, c_dtr_n, c_cts_n, c_dsr_n, c_dcd_n, c_ri_n;
	logic [1:0] diff_on;
	qsp_mode_t  m3;

	// ----------------------------------------
	// Mode control and host read data
	// ----------------------------------------
	always_comb begin
		cfg_next = cfg_we ? cfg_wdata : cfg_reg;
		rdata_next = host_req.re ? c_rd[host_req.ch] : rdata_reg;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= `QSP_CFG_RST;
			rdata_reg <= 8'h00;
		end else begin
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cfg        = cfg_reg;
	assign host_rdata = rdata_reg;
	assign m3         = qsp_ch3_mode(cfg_reg);

	// ----------------------------------------
	// Line routing per channel mode
	// ----------------------------------------
	always_comb begin
		c_rxd   = {1'b1, rs232_rxd};
		c_cts_n = {1'b1, rs232_cts_n};
		c_dsr_n = {1'b1, rs232_dsr_n};
		c_dcd_n = {1'b1, rs232_dcd_n};
		c_ri_n  = {1'b1, rs232_ri_n};
		// Differential driver gated by request-to-send in RS485
		diff_on[0] = m3 == QSP_RS422 || (m3 == QSP_RS485 && !c_rts_n[2]);
		diff_on[1] = !cfg_reg.ch4_rs485_select || !c_rts_n[3];
		if (m3 != QSP_RS232) begin
			// Half duplex line hears its own transmission
			c_rxd[2] = (m3 == QSP_RS485 && diff_on[0]) ? c_txd[2] : diff_rxd[0];
			c_cts_n[2] = 1'b1;
			c_dsr_n[2] = 1'b1;
			c_dcd_n[2] = 1'b1;
			c_ri_n[2] = 1'b1;
		end
		c_rxd[3] = (cfg_reg.ch4_rs485_select && diff_on[1]) ? c_txd[3] : diff_rxd[1];
	end

	assign diff_drv_en = diff_on;
	assign diff_txd    = c_txd[3:2];
	assign rs232_txd   = c_txd[2:0];
	assign rs232_rts_n = c_rts_n[2:0];
	assign rs232_dtr_n = c_dtr_n[2:0];

	// ----------------------------------------
	// Four channels
	// ----------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_ch
		qsp_chan #(.DEPTH(DEPTH)) u_ch (
			.mclk   (mclk),
			.rst_n  (rst_n),
			.req    (host_req),
			.sel    (host_req.ch == 2'(i)),
			.rd_val (c_rd[i]),
			.rxd    (c_rxd[i]),
			.cts_n  (c_cts_n[i]),
			.dsr_n  (c_dsr_n[i]),
			.dcd_n  (c_dcd_n[i]),
			.ri_n   (c_ri_n[i]),
			.txd    (c_txd[i]),
			.rts_n  (c_rts_n[i]),
			.dtr_n  (c_dtr_n[i]),
			.irq    (chan_irq[i])
		);
	end

	mode_rs232_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg.ch3_rs232_select |-> !diff_drv_en[0] && c_rxd[2] == rs232_rxd[2])
		else $error("third channel not in RS232 mode");
	mode_rs422_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!cfg.ch3_rs232_select && cfg.ch3_rs422_select |-> diff_drv_en[0]
			&& c_rxd[2] == diff_rxd[0])
		else $error("third channel not in RS422 mode");
	reset_dflt_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> cfg == `QSP_CFG_RST)
		else $error("control lines not high after reset");
	cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg_we |=> cfg == $past(cfg_wdata) ##1 (cfg == $past(cfg) || $past(cfg_we)))
		else $error("control write not applied or not held");
	drv_rts_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!cfg.ch3_rs232_select && !cfg.ch3_rs422_select
			|-> diff_drv_en[0] == !rs232_rts_n[2])
		else $error("RS485 driver not following request-to-send");
	echo_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfg.ch4_rs485_select && diff_drv_en[1] |-> c_rxd[3] == diff_txd[1])
		else $error("RS485 transmission not echoed");
	ch4_diff_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!cfg.ch4_rs485_select |-> diff_drv_en[1] && c_rxd[3] == diff_rxd[1])
		else $error("fourth channel RS422 routing wrong");

endmodule
`default_nettype wire

// file: verification/qsp_remote.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Far-end serial station, 8 data bits, one stop bit
// ----------------------------------------
module qsp_remote #(
	parameter int BIT_CYC = 16
) (
	input  wire logic mclk,
	input  wire logic line_in,
	output logic      line_out
);
	logic [7:0] rx_q[$];
	logic [7:0] shift;

	initial begin
		line_out = 1'b1;
	end

	// Frame out, LSB first, back to mark when done
	task automatic send(input logic [7:0] b);
		@(negedge mclk);
		line_out = 1'b0;
		repeat (BIT_CYC) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			line_out = b[i];
			repeat (BIT_CYC) @(negedge mclk);
		end
		line_out = 1'b1;
		repeat (BIT_CYC) @(negedge mclk);
	endtask

	// Frame in, sampled mid-bit
	always begin
		@(negedge line_in);
		repeat (BIT_CYC / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge mclk);
			shift[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge mclk);
		rx_q.push_back(shift);
	end
endmodule

`default_nettype wire

// file: verification/test_quad_serial_port_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsp_consts.svh"

module test_quad_serial_port_mode_control;
	import qsp_pkg::*;

	typedef struct {
		string      name;
		logic [7:0] val;
	} qsp_note_t;

	logic       mclk, rst_n, cfg_we, far0_out, far3_out;
	qsp_req_t   req;
	qsp_cfg_t   cfg_wdata, cfg, c;
	logic [7:0] host_rdata, d;
	logic [3:0] chan_irq;
	logic [2:0] txd, cts_n, dsr_n, dcd_n, ri_n, rts_n, dtr_n;
	logic [1:0] rxd_idle, diff_txd, drv_en, rd_pipe;
	logic       rxd3_idle;
	wire  [2:0] rs232_rxd;
	wire  [1:0] diff_rxd;
	int         failures, checked, cycles;
	qsp_note_t  exp_q[$];
	qsp_note_t  n;
	logic [7:0] tx_exp[$];

	assign rs232_rxd = {rxd_idle, far0_out};
	assign diff_rxd  = {far3_out, rxd3_idle};

	qsp_top i_qsp_top (
		.mclk(mclk), .rst_n(rst_n), .host_req(req), .host_rdata(host_rdata),
		.chan_irq(chan_irq), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg(cfg),
		.rs232_rxd(rs232_rxd), .rs232_txd(txd), .rs232_cts_n(cts_n),
		.rs232_dsr_n(dsr_n), .rs232_dcd_n(dcd_n), .rs232_ri_n(ri_n),
		.rs232_rts_n(rts_n), .rs232_dtr_n(dtr_n), .diff_rxd(diff_rxd),
		.diff_txd(diff_txd), .diff_drv_en(drv_en)
	);
	qsp_remote i_far0 (.mclk(mclk), .line_in(txd[0]), .line_out(far0_out));
	qsp_remote i_far3 (.mclk(mclk), .line_in(diff_txd[1]), .line_out(far3_out));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [7:0] e, input logic [7:0] got);
		checked++;
		if (got !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, e, got);
		end
	endtask

	task automatic complete_run;
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] v);
		@(negedge mclk);
		req = '{we: 1'b1, re: 1'b0, ch: ch, addr: a, wdata: v};
		@(negedge mclk);
		req.we = 1'b0;
	endtask

	task automatic reg_rd(input logic [1:0] ch, input logic [2:0] a, input string name,
		input logic [7:0] e);
		exp_q.push_back('{name, e});
		@(negedge mclk);
		req = '{we: 1'b0, re: 1'b1, ch: ch, addr: a, wdata: 8'h00};
		@(negedge mclk);
		req.re = 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	task automatic cfg_wr(input qsp_cfg_t v);
		@(negedge mclk);
		cfg_we = 1'b1;
		cfg_wdata = v;
		@(negedge mclk);
		cfg_we = 1'b0;
		@(negedge mclk);
	endtask

	task automatic frame_seen(input logic [7:0] b);
		if (tx_exp.size() > 0) begin
			check("txd", tx_exp.pop_front(), b);
		end else begin
			failures++;
			$display("MISMATCH txd expected none seen %h", b);
		end
	endtask

	// ----------------------------------------
	// Result watchers
	// ----------------------------------------
	always @(posedge mclk) begin
		rd_pipe <= {rd_pipe[0], req.re};
		cycles++;
		if (cycles == 8000) begin
			failures++;
			$display("MISMATCH cycles expected below %0d seen %0d", 8000, cycles);
			complete_run();
		end
	end

	always @(negedge mclk) begin
		if (rd_pipe[1] === 1'b1) begin
			if (exp_q.size() > 0) begin
				n = exp_q.pop_front();
				check(n.name, n.val, host_rdata);
			end else begin
				failures++;
				$display("MISMATCH read expected none seen %h", host_rdata);
			end
		end
		if (i_far0.rx_q.size() > 0) frame_seen(i_far0.rx_q.pop_front());
		if (i_far3.rx_q.size() > 0) frame_seen(i_far3.rx_q.pop_front());
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		cfg_we = 1'b0;
		cfg_wdata = '0;
		req = '0;
		rd_pipe = 2'b00;
		{cts_n, dsr_n, dcd_n, ri_n} = 12'hFFF;
		rxd_idle = 2'b11;
		rxd3_idle = 1'b1;
		failures = 0;
		checked = 0;
		cycles = 0;
		void'($urandom(31));
		repeat (5) @(negedge mclk);
		check("cfg reset", 8'h7F, 8'(cfg));
		check("drv reset", 8'h00, 8'(drv_en));
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		for (int ch = 0; ch < 4; ch++) begin
			reg_wr(2'(ch), `QSP_A_IER, 8'h02);
			@(negedge mclk);
			check("irq on", 8'(1 << ch), 8'(chan_irq));
			reg_rd(2'(ch), `QSP_A_IIR, "iir", 8'hC2);
			check("irq off", 8'h00, 8'(chan_irq));
			reg_wr(2'(ch), `QSP_A_IER, 8'h00);
			d = 8'($urandom);
			reg_wr(2'(ch), `QSP_A_SCR, d);
			reg_rd(2'(ch), `QSP_A_SCR, "scratch", d);
			reg_wr(2'(ch), `QSP_A_LCR, 8'h03);
		end
		for (int m = 0; m < 4; m++) begin
			c = qsp_cfg_t'(7'($urandom));
			c.ch3_rs232_select = m[1];
			c.ch3_rs422_select = m[0];
			c.ch4_rs485_select = m[0];
			cfg_wr(c);
			check("cfg", 8'(c), 8'(cfg));
			check("drv mode", {6'h00, !m[0], m == 1}, 8'(drv_en));
		end
		c = qsp_cfg_t'(`QSP_CFG_RST);
		c.ch4_termination_n = 1'b0;
		cfg_wr(c);
		d = 8'($urandom);
		tx_exp.push_back(d);
		reg_wr(2'd0, `QSP_A_DATA, d);
		repeat (250) @(negedge mclk);
		check("tx pending", 8'h00, 8'(tx_exp.size()));
		d = 8'($urandom);
		i_far0.send(d);
		repeat (40) @(negedge mclk);
		reg_rd(2'd0, `QSP_A_LSR, "lsr", 8'h61);
		reg_rd(2'd0, `QSP_A_DATA, "rbr", d);
		reg_rd(2'd0, `QSP_A_LSR, "lsr", 8'h60);
		cts_n[1] = 1'b0;
		repeat (4) @(negedge mclk);
		reg_rd(2'd1, `QSP_A_MSR, "msr", 8'h11);
		reg_rd(2'd1, `QSP_A_MSR, "msr", 8'h10);
		reg_wr(2'd1, `QSP_A_MCR, 8'h03);
		check("rts_n", 8'h05, 8'(rts_n));
		check("dtr_n", 8'h05, 8'(dtr_n));
		reg_wr(2'd1, `QSP_A_MCR, 8'h13);
		check("loop rts_n", 8'h07, 8'(rts_n));
		reg_rd(2'd1, `QSP_A_MSR, "loop msr", 8'h32);
		reg_wr(2'd1, `QSP_A_MCR, 8'h00);
		reg_wr(2'd2, `QSP_A_LCR, 8'h83);
		d = 8'($urandom);
		reg_wr(2'd2, `QSP_A_DATA, d);
		reg_rd(2'd2, `QSP_A_DATA, "divisor", d);
		reg_wr(2'd2, `QSP_A_LCR, 8'h03);
		reg_wr(2'd3, `QSP_A_MCR, 8'h02);
		@(negedge mclk);
		check("drv rts", 8'h02, 8'(drv_en));
		d = 8'($urandom);
		tx_exp.push_back(d);
		reg_wr(2'd3, `QSP_A_DATA, d);
		repeat (250) @(negedge mclk);
		check("tx pending", 8'h00, 8'(tx_exp.size()));
		reg_rd(2'd3, `QSP_A_LSR, "lsr", 8'h61);
		reg_rd(2'd3, `QSP_A_DATA, "echo", d);
		reg_wr(2'd3, `QSP_A_MCR, 8'h00);
		@(negedge mclk);
		check("drv off", 8'h00, 8'(drv_en));
		complete_run();
	end
endmodule

`default_nettype wire
